/* design/scpl_pkg.sv */
// shared constants and types of the system control pin logic
package scpl_pkg;
   // oscillator rate and bus clock division
   localparam int unsigned OSC_PERIOD_NS   = 100;
   localparam int unsigned BUS_DIV         = 4;
   localparam logic [1:0]  DIV_LAST        = 2'(BUS_DIV - 1);
   localparam logic [1:0]  DIV_HI_START    = 2'(BUS_DIV / 2);
   // internal reset drive length in bus cycles and internal/external sense window in osc cycles
   localparam int unsigned RST_DRIVE_BUS   = 4;
   localparam logic [3:0]  RST_DRIVE_LAST  = 4'(RST_DRIVE_BUS * BUS_DIV - 1);
   localparam logic [3:0]  RST_SENSE_LIMIT = 4'(2 * BUS_DIV);
   // register map, byte addresses
   localparam logic [7:0]  ADDR_OPTION     = 8'h00;
   localparam logic [7:0]  ADDR_CCR        = 8'h04;
   localparam logic [7:0]  ADDR_STATUS     = 8'h08;
   // option register fields
   localparam int unsigned OPT_EDGE_BIT    = 0;
   localparam int unsigned OPT_CLKDIS_BIT  = 1;
   localparam int unsigned OPT_STOP_BIT    = 2;
   localparam logic [2:0]  OPT_RESET       = 3'h0;
   // condition code register fields
   localparam int unsigned CCR_I_BIT       = 0;
   localparam int unsigned CCR_X_BIT       = 1;
   localparam logic [1:0]  CCR_RESET       = 2'h3;
   // status register fields
   localparam int unsigned ST_MODE_LSB     = 0;
   localparam int unsigned ST_RSTINT_BIT   = 2;
   localparam int unsigned ST_IRQ_BIT      = 3;
   localparam int unsigned ST_NMI_BIT      = 4;
   localparam int unsigned ST_PEND_BIT     = 5;
   localparam int unsigned ST_STOP_BIT     = 6;
   typedef enum logic [1:0] {
      SCPL_MODE_SINGLE, SCPL_MODE_EXPANDED, SCPL_MODE_TEST, SCPL_MODE_BOOT
   } scpl_mode_e;
   typedef enum logic [1:0] {RS_RUN, RS_DRIVE, RS_WAIT_HIGH, RS_EXT_LOW} scpl_rst_e;
endpackage : scpl_pkg

/* design/scpl_ctl_if.sv */
// carrier between the control top and its clock and interrupt helpers
`timescale 1ns/1ps
interface scpl_ctl_if;
   logic stop;
   logic out_en;
   logic phase_hi;
   logic cyc_start;
   logic bus_clk;
   logic in_reset;
   logic edge_sel;
   logic ack;
   logic pending;
   logic irq_req;
   modport top     (output stop, out_en, in_reset, edge_sel, ack,
                    input phase_hi, cyc_start, bus_clk, pending, irq_req);
   modport clkgen  (input stop, out_en, in_reset, output phase_hi, cyc_start, bus_clk);
   modport irqsense(input in_reset, edge_sel, ack, output pending, irq_req);
endinterface : scpl_ctl_if

/* design/scpl_clkdiv.sv */
// bus clock generator: divide by four, phase flags, stop halt
`timescale 1ns/1ps
module scpl_clkdiv
   import scpl_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic nrst_in,
   scpl_ctl_if.clkgen ctl
);
   typedef struct packed {
      logic [1:0] div;
      logic       bus_clk;
      logic       pin;
   } scpl_div_s;
   scpl_div_s st_r;
   scpl_div_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (ctl.in_reset)
      begin
         st_nxt.div = 2'h0;
      end
      else if (!ctl.stop) // R6
      begin
         st_nxt.div = (st_r.div == DIV_LAST) ? 2'h0 : st_r.div + 2'h1; // R4
      end
      st_nxt.bus_clk = (st_nxt.div >= DIV_HI_START); // R5
      st_nxt.pin     = st_nxt.bus_clk & ctl.out_en & ~ctl.stop; // R7
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign ctl.bus_clk   = st_r.pin;
   assign ctl.phase_hi  = st_r.bus_clk;
   assign ctl.cyc_start = (st_r.div == DIV_LAST) & ~ctl.stop & ~ctl.in_reset;
endmodule : scpl_clkdiv

/* design/scpl_irqsense.sv */
// maskable interrupt input: edge or level sensing
`timescale 1ns/1ps
module scpl_irqsense
   import scpl_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic nrst_in,
   input  wire logic irq_n_in,
   scpl_ctl_if.irqsense ctl
);
   typedef struct packed {
      logic prev;
      logic pending;
   } scpl_irq_s;
   scpl_irq_s st_r;
   scpl_irq_s st_nxt;
   logic      fall;

   always_comb
   begin
      st_nxt      = st_r;
      fall        = st_r.prev & ~irq_n_in;
      st_nxt.prev = irq_n_in;
      if (ctl.in_reset)
      begin
         st_nxt.pending = 1'b0;
         st_nxt.prev    = 1'b1;
      end
      else if (fall & ctl.edge_sel) // R8
      begin
         st_nxt.pending = 1'b1;
      end
      else if (ctl.ack)
      begin
         st_nxt.pending = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         st_r <= '{prev: 1'b1, pending: 1'b0};
      else
         st_r <= st_nxt;
   end

   assign ctl.pending = st_r.pending;
   // level mode requests for as long as the line stays low
   assign ctl.irq_req = ctl.edge_sel ? st_r.pending : ~irq_n_in; // R8 R15
endmodule : scpl_irqsense

/* design/scpl_top.sv */
// system control pin logic: reset pin, bus clock, interrupts, mode pins
//
// Functional notes
// R1: external low reset initialises all logic; here the bus answer (ack, read data) is not reset
// R2: monitor or watchdog failure pulls reset low
// R3: pin high within two bus clocks means internal
// R4: bus clock is oscillator divided by four
// R5: low phase processes, high phase accesses data
// R6: stop mode halts every clock and output; here only the bus clock divider, clock output and cycle start halt
// R7: software may disable clock output in single-chip
// R8: maskable input falling edge or low level
// R9: maskable trigger defaults to level on reset
// R10: reset sets non-maskable mask until software clears
// R11: non-maskable input level sensitive when unmasked
// R12: shared interrupt sources use open-drain drivers
// R13: several maskable sources need level mode
// R14: sources hold line low until acknowledged
// R15: still-low line interrupts again after unmasking
// R16: mode pins pick one of four modes
// R17: mode pin later shows opcode fetch low
// R18: system holds reset low across supply loss
// R19: mode latched at reset release, then held
`timescale 1ns/1ps
module scpl_top
   import scpl_pkg::*;
#(
   parameter bit CLK_ALWAYS_ON = 1'b0
)
(
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   // wishbone classic slave
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   // reset pin, open drain
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe_out,
   input  wire logic        clock_monitor_fail_in,
   input  wire logic        watchdog_timer_fail_in,
   output logic             chip_reset_n_out,
   // bus clock
   output logic             bus_clk_out,
   output logic             bus_phase_hi_out,
   output logic             bus_cycle_start_out,
   // interrupts
   input  wire logic        irq_n_in,
   input  wire logic        nonmaskable_int_n_in,
   input  wire logic        int_ack_in,
   output logic             irq_req_out,
   output logic             nmi_req_out,
   // mode pins, a doubles as open-drain opcode fetch output
   input  wire logic        mode_select_a_in,
   output logic             mode_select_a_out,
   output logic             mode_select_a_oe_out,
   input  wire logic        mode_select_b_in,
   input  wire logic        opcode_fetch_in,
   output scpl_pkg::scpl_mode_e mode_out
);
   import scpl_pkg::*;

   typedef struct packed {
      scpl_rst_e  rst_state;
      logic [3:0] rst_cnt;
      logic       rst_internal;
      logic       chip_rst_n;
      scpl_mode_e mode;
      logic       mode_valid;
      logic       fetch_drive;
      logic [2:0] option;
      logic [1:0] condition_code_reg;
      logic       irq_req;
      logic       nmi_req;
      logic       ack;
      logic [31:0] rdata;
   } scpl_top_s;

   scpl_top_s st_r;
   scpl_top_s st_nxt;

   scpl_ctl_if ctl ();

   logic       in_reset;
   logic       fail;
   logic       wb_req;
   logic       wb_wr;
   logic       single_chip;
   logic [31:0] status_word;

   // byte-enable write merge into a narrow field
   function automatic logic [2:0] opt_merge(input logic [2:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
      opt_merge = sel[0] ? wd[2:0] : old_v;
   endfunction : opt_merge

   function automatic logic sel_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
      sel_hit = (adr == reg_adr);
   endfunction : sel_hit

   scpl_clkdiv u_clkdiv (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .ctl        (ctl.clkgen)
   );

   scpl_irqsense u_irqsense (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .irq_n_in   (irq_n_in),
      .ctl        (ctl.irqsense)
   );

   assign fail        = clock_monitor_fail_in | watchdog_timer_fail_in;
   assign in_reset    = ~reset_pin_in | (st_r.rst_state != RS_RUN); // R1
   assign single_chip = (st_r.mode == SCPL_MODE_SINGLE) | (st_r.mode == SCPL_MODE_BOOT);
   assign wb_req      = wb_cyc_in & wb_stb_in & ~st_r.ack;
   assign wb_wr       = wb_req & wb_we_in;

   assign ctl.in_reset = in_reset;
   assign ctl.stop     = st_r.option[OPT_STOP_BIT]; // R6
   assign ctl.out_en   = CLK_ALWAYS_ON | ~single_chip | ~st_r.option[OPT_CLKDIS_BIT]; // R7
   assign ctl.edge_sel = st_r.option[OPT_EDGE_BIT];
   assign ctl.ack      = int_ack_in;

   always_comb
   begin
      status_word = 32'h0;
      status_word[ST_MODE_LSB +: 2] = st_r.mode;
      status_word[ST_RSTINT_BIT]    = st_r.rst_internal;
      status_word[ST_IRQ_BIT]       = st_r.irq_req;
      status_word[ST_NMI_BIT]       = st_r.nmi_req;
      status_word[ST_PEND_BIT]      = ctl.pending;
      status_word[ST_STOP_BIT]      = st_r.option[OPT_STOP_BIT];
   end

   always_comb
   begin
      st_nxt = st_r;

      // reset pin sequencer
      case (st_r.rst_state)
         RS_RUN:
         begin
            st_nxt.rst_cnt = 4'h0;
            if (fail)
            begin
               st_nxt.rst_state = RS_DRIVE; // R2
            end
            else if (!reset_pin_in)
            begin
               st_nxt.rst_state = RS_EXT_LOW; // R1
            end
         end
         RS_DRIVE:
         begin
            if (st_r.rst_cnt == RST_DRIVE_LAST)
            begin
               st_nxt.rst_state = RS_WAIT_HIGH;
               st_nxt.rst_cnt   = 4'h0;
            end
            else
            begin
               st_nxt.rst_cnt = st_r.rst_cnt + 4'h1;
            end
         end
         RS_WAIT_HIGH:
         begin
            if (reset_pin_in)
            begin
               st_nxt.rst_state    = RS_RUN;
               st_nxt.rst_internal = (st_r.rst_cnt < RST_SENSE_LIMIT); // R3
            end
            else if (st_r.rst_cnt == RST_SENSE_LIMIT)
            begin
               st_nxt.rst_state = RS_EXT_LOW; // R3
            end
            else
            begin
               st_nxt.rst_cnt = st_r.rst_cnt + 4'h1;
            end
         end
         RS_EXT_LOW:
         begin
            if (reset_pin_in)
            begin
               st_nxt.rst_state    = RS_RUN;
               st_nxt.rst_internal = 1'b0; // R3
            end
         end
         default:
         begin
            st_nxt.rst_state = RS_RUN;
         end
      endcase

      st_nxt.chip_rst_n = ~in_reset; // R1

      // mode pins follow while the reset pin is low, frozen after release
      if (!reset_pin_in)
      begin
         st_nxt.mode       = scpl_mode_e'({mode_select_b_in, mode_select_a_in}); // R16 R19
         st_nxt.mode_valid = 1'b0;
      end
      else if (!in_reset)
      begin
         st_nxt.mode_valid = 1'b1; // R19
      end

      // opcode fetch marker, held for one whole bus cycle
      if (!st_r.mode_valid || in_reset)
      begin
         st_nxt.fetch_drive = 1'b0;
      end
      else if (ctl.cyc_start)
      begin
         st_nxt.fetch_drive = opcode_fetch_in; // R17
      end

      // register writes
      if (wb_wr && sel_hit(wb_adr_in, ADDR_OPTION))
      begin
         st_nxt.option = opt_merge(st_r.option, wb_dat_in, wb_sel_in); // R8
      end
      if (wb_wr && sel_hit(wb_adr_in, ADDR_CCR) && wb_sel_in[0])
      begin
         st_nxt.condition_code_reg[CCR_I_BIT] = wb_dat_in[CCR_I_BIT];
         // software can clear the non-maskable mask but never set it again; only reset sets it
         st_nxt.condition_code_reg[CCR_X_BIT] = st_r.condition_code_reg[CCR_X_BIT] & wb_dat_in[CCR_X_BIT]; // R10
      end

      // interrupt requests
      st_nxt.irq_req = ctl.irq_req & ~st_r.condition_code_reg[CCR_I_BIT]; // R15
      st_nxt.nmi_req = ~nonmaskable_int_n_in & ~st_r.condition_code_reg[CCR_X_BIT]; // R11

      // any request wakes from stop, winning over a same-cycle write
      if (st_nxt.irq_req || st_nxt.nmi_req)
      begin
         st_nxt.option[OPT_STOP_BIT] = 1'b0;
      end

      // bus answer
      st_nxt.ack   = wb_req;
      st_nxt.rdata = st_r.rdata;
      if (wb_req && !wb_we_in)
      begin
         if (sel_hit(wb_adr_in, ADDR_OPTION))
         begin
            st_nxt.rdata = {29'h0, st_r.option};
         end
         else if (sel_hit(wb_adr_in, ADDR_CCR))
         begin
            st_nxt.rdata = {30'h0, st_r.condition_code_reg};
         end
         else if (sel_hit(wb_adr_in, ADDR_STATUS))
         begin
            st_nxt.rdata = status_word;
         end
         else
         begin
            st_nxt.rdata = 32'h0;
         end
      end

      // reset re-initialises control state
      if (in_reset)
      begin
         st_nxt.option  = OPT_RESET; // R9
         st_nxt.condition_code_reg     = CCR_RESET; // R10
         st_nxt.irq_req = 1'b0;
         st_nxt.nmi_req = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_r              <= '0;
         st_r.rst_state    <= RS_EXT_LOW;
         st_r.option       <= OPT_RESET;
         st_r.condition_code_reg          <= CCR_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign wb_ack_out           = st_r.ack;
   assign wb_dat_out           = st_r.rdata;
   assign reset_pin_out        = 1'b0;
   assign reset_pin_oe_out     = (st_r.rst_state == RS_DRIVE); // R2
   assign chip_reset_n_out     = st_r.chip_rst_n;
   assign bus_clk_out          = ctl.bus_clk; // R4
   assign bus_phase_hi_out     = ctl.phase_hi; // R5
   assign bus_cycle_start_out  = ctl.cyc_start;
   assign irq_req_out          = st_r.irq_req;
   assign nmi_req_out          = st_r.nmi_req;
   assign mode_select_a_out    = 1'b0;
   assign mode_select_a_oe_out = st_r.fetch_drive; // R17
   assign mode_out             = st_r.mode;
endmodule : scpl_top

/* test/scpl_board.sv */
// board model: reset circuit, mode straps, wired-or interrupt sources
`timescale 1ns/1ps
module scpl_board
(
   input  wire logic       ref_clk_in,
   input  wire logic       reset_pin_oe_in,
   input  wire logic       hold_low_in,
   input  wire logic [3:0] slow_in,
   input  wire logic [1:0] strap_in,
   input  wire logic       mode_a_oe_in,
   input  wire logic [1:0] irq_src_in,
   input  wire logic       nmi_src_in,
   input  wire logic       int_ack_in,
   output logic            reset_pin_out,
   output logic            mode_a_pin_out,
   output logic            mode_b_pin_out,
   output logic            irq_n_out,
   output logic            nmi_n_out
);
   logic [3:0] stretch_r = 4'h0;
   logic [1:0] irq_pend_r = 2'h0;
   logic       nmi_pend_r = 1'b0;
   always_ff @(posedge ref_clk_in)
   begin
      stretch_r  <= reset_pin_oe_in ? slow_in : stretch_r - 4'(stretch_r != 4'h0);
      irq_pend_r <= (irq_pend_r | irq_src_in)
                    & ~(int_ack_in ? (irq_pend_r[0] ? 2'h1 : 2'h2) : 2'h0);
      nmi_pend_r <= (nmi_pend_r | nmi_src_in) & !int_ack_in;
   end
   // open drain lines with pull-ups
   assign reset_pin_out  = !(reset_pin_oe_in || hold_low_in || stretch_r != 4'h0);
   assign mode_a_pin_out = mode_a_oe_in ? 1'b0 : strap_in[0];
   assign mode_b_pin_out = strap_in[1];
   assign irq_n_out      = !(|irq_pend_r);
   assign nmi_n_out      = !nmi_pend_r;
endmodule : scpl_board

/* test/scpl_top_chk.sv */
// port assertions of the system control pin logic
`timescale 1ns/1ps
module scpl_top_chk
   import scpl_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic reset_pin_in,
   input wire logic reset_pin_oe_out,
   input wire logic clock_monitor_fail_in,
   input wire logic watchdog_timer_fail_in,
   input wire logic chip_reset_n_out,
   input wire logic bus_clk_out,
   input wire logic bus_phase_hi_out,
   input wire logic bus_cycle_start_out,
   input wire logic nonmaskable_int_n_in,
   input wire logic irq_req_out,
   input wire logic nmi_req_out,
   input wire logic mode_select_a_in,
   input wire logic mode_select_b_in,
   input wire logic mode_select_a_oe_out,
   input wire scpl_pkg::scpl_mode_e mode_out
);
   logic [4:0] drive_cnt_r;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   always_ff @(posedge ref_clk_in or negedge nrst_in)
      if (!nrst_in)
         drive_cnt_r <= 5'h00;
      else
         drive_cnt_r <= reset_pin_oe_out ? drive_cnt_r + 5'h01 : 5'h00;
   AST_WB_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("no ack after request");
   AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   AST_DATA_PHASE: assert property ((bus_clk_out || bus_cycle_start_out) |-> bus_phase_hi_out)
      else $error("bus clock high outside data phase");
   AST_LOW_PHASE: assert property ($fell(bus_phase_hi_out) |-> !bus_phase_hi_out[*2])
      else $error("low phase too short");
   AST_FAIL_DRIVE: assert property ((watchdog_timer_fail_in || clock_monitor_fail_in)
      && chip_reset_n_out && reset_pin_in |=> reset_pin_oe_out) else $error("fail not driven");
   AST_DRIVE_LEN: assert property ($fell(reset_pin_oe_out) |-> drive_cnt_r == 5'h10)
      else $error("reset drive length wrong");
   AST_PIN_RESET: assert property (!reset_pin_in |=> !chip_reset_n_out && !irq_req_out
      && !nmi_req_out) else $error("pin reset not applied");
   AST_NMI_IDLE: assert property (nonmaskable_int_n_in |=> !nmi_req_out)
      else $error("nmi request without low line");
   AST_MODE_FOLLOW: assert property (!reset_pin_in |=>
      mode_out == $past({mode_select_b_in, mode_select_a_in})) else $error("mode not taken");
   AST_MODE_HOLD: assert property (reset_pin_in && $past(reset_pin_in) |-> $stable(mode_out))
      else $error("mode changed after release");
   AST_FETCH_CAUSE: assert property ($changed(mode_select_a_oe_out) |->
      $past(bus_cycle_start_out) || !$past(reset_pin_in)) else $error("fetch marker off cycle");
   AST_FETCH_QUIET: assert property (!reset_pin_in |=> !mode_select_a_oe_out)
      else $error("fetch marker in reset");
   cover property ($fell(reset_pin_oe_out));
   cover property ($rose(nmi_req_out));
   cover property ($rose(irq_req_out));
endmodule : scpl_top_chk
bind scpl_top scpl_top_chk u_chk (.ref_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
   .reset_pin_in, .reset_pin_oe_out, .clock_monitor_fail_in, .watchdog_timer_fail_in,
   .chip_reset_n_out, .bus_clk_out, .bus_phase_hi_out, .bus_cycle_start_out,
   .nonmaskable_int_n_in, .irq_req_out, .nmi_req_out, .mode_select_a_in, .mode_select_b_in,
   .mode_select_a_oe_out, .mode_out);

/* test/scpl_top_test.sv */
// self-checking bench of the system control pin logic
`timescale 1ns/1ps
module scpl_top_test;
   import scpl_pkg::*;
   logic        ref_clk_in, nrst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, hold;
   logic [7:0]  wb_adr_in;
   logic [3:0]  wb_sel_in, slow;
   logic [31:0] wb_dat_in, wb_dat_out, q;
   logic        reset_pin_in, reset_pin_oe_out, clock_monitor_fail_in, watchdog_timer_fail_in;
   logic        chip_reset_n_out, bus_clk_out, irq_n_in, nonmaskable_int_n_in, int_ack_in;
   logic        irq_req_out, nmi_req_out, mode_select_a_in, mode_select_a_oe_out, nmi_src;
   logic        mode_select_b_in, opcode_fetch_in;
   logic [1:0]  strap, irq_src;
   scpl_mode_e  mode_out;
   int          n_errors, tests_run, cycles, e;
   scpl_top dut (.ref_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .reset_pin_in, .reset_pin_out(),
      .reset_pin_oe_out, .clock_monitor_fail_in, .watchdog_timer_fail_in, .chip_reset_n_out,
      .bus_clk_out, .bus_phase_hi_out(), .bus_cycle_start_out(), .irq_n_in,
      .nonmaskable_int_n_in, .int_ack_in, .irq_req_out, .nmi_req_out, .mode_select_a_in,
      .mode_select_a_out(), .mode_select_a_oe_out, .mode_select_b_in, .opcode_fetch_in,
      .mode_out);
   scpl_board board (.ref_clk_in, .reset_pin_oe_in(reset_pin_oe_out), .hold_low_in(hold),
      .slow_in(slow), .strap_in(strap), .mode_a_oe_in(mode_select_a_oe_out),
      .irq_src_in(irq_src), .nmi_src_in(nmi_src), .int_ack_in, .reset_pin_out(reset_pin_in),
      .mode_a_pin_out(mode_select_a_in), .mode_b_pin_out(mode_select_b_in),
      .irq_n_out(irq_n_in), .nmi_n_out(nonmaskable_int_n_in));
   initial
   begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in)
   begin
      opcode_fetch_in <= 1'($urandom);
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         finish_test();
      end
   end
   function automatic logic [31:0] exp_status(logic [1:0] m, logic k, logic i, logic p);
      return 32'(m) | 32'(k) << ST_RSTINT_BIT | 32'(i) << ST_IRQ_BIT | 32'(p) << ST_PEND_BIT;
   endfunction : exp_status
   function automatic logic internal(int s);
      return s < 2 * BUS_DIV;
   endfunction : internal
   task finish_test();
      if (n_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task chk(string name, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task wb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= w;
      wb_adr_in <= a;
      wb_dat_in <= d;
      wb_sel_in <= 4'h1;
      do
      begin
         @(posedge ref_clk_in);
         n++;
      end
      while (wb_ack_out !== 1'b1 && n < 50);
      q = wb_dat_out;
      n_errors += int'(n == 50);
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask : wb
   task rd(string name, logic [7:0] a, logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(name, q, exp);
   endtask : rd
   task step(int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : step
   task wait_run();
      int n;
      n = 0;
      while ((reset_pin_in !== 1'b1 || chip_reset_n_out !== 1'b1) && n < 200)
      begin
         step(1);
         n++;
      end
      n_errors += int'(n == 200);
   endtask : wait_run
   task pin_reset(logic [1:0] m);
      strap <= m;
      hold  <= 1'b1;
      step(3);
      hold  <= 1'b0;
      strap <= 2'($urandom);
      wait_run();
   endtask : pin_reset
   task src(logic [1:0] i, logic n);
      irq_src <= i;
      nmi_src <= n;
      step(1);
      irq_src <= 2'h0;
      nmi_src <= 1'b0;
      step(2);
   endtask : src
   task ack_pulse();
      int_ack_in <= 1'b1;
      step(1);
      int_ack_in <= 1'b0;
      step(2);
   endtask : ack_pulse
   task edges(int n);
      logic p;
      p = bus_clk_out;
      e = 0;
      repeat (n)
      begin
         step(1);
         e += int'(bus_clk_out === 1'b1 && p === 1'b0);
         p = bus_clk_out;
      end
   endtask : edges
   initial
   begin
      void'($urandom(32'hC112));
      {nrst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in} = '0;
      {clock_monitor_fail_in, watchdog_timer_fail_in, int_ack_in, nmi_src} = '0;
      {irq_src, strap, slow, opcode_fetch_in} = '0;
      hold = 1'b1;
      step(6);
      nrst_in <= 1'b1;
      for (int m = 1; m <= 4; m++)
      begin
         wb(1'b1, ADDR_CCR, 32'h0);
         wb(1'b1, ADDR_OPTION, 32'h1);
         pin_reset(2'(m));
         chk("mode", 32'(mode_out), 32'(m % 4));
         rd("ccr", ADDR_CCR, 32'(CCR_RESET));
         rd("option", ADDR_OPTION, 32'(OPT_RESET));
      end
      wb(1'b1, ADDR_STATUS, 32'hFF);
      rd("status", ADDR_STATUS, exp_status(2'h0, 1'b0, 1'b0, 1'b0));
      rd("unmapped", 8'hFC, 32'h0);
      edges(40);
      chk("bus clock", e, 40 / BUS_DIV);
      wb(1'b1, ADDR_OPTION, 32'h2);
      edges(40);
      chk("clock off", e, 0);
      wb(1'b1, ADDR_OPTION, 32'h0);
      src(2'h0, 1'b1);
      chk("nmi masked", nmi_req_out, 0);
      wb(1'b1, ADDR_CCR, 32'h1);
      step(2);
      chk("nmi", nmi_req_out, 1);
      ack_pulse();
      chk("nmi off", nmi_req_out, 0);
      wb(1'b1, ADDR_CCR, 32'h2);
      rd("x clear only", ADDR_CCR, 32'h0);
      src(2'h3, 1'b0);
      chk("irq level", irq_req_out, 1);
      ack_pulse();
      chk("irq held", irq_req_out, 1);
      wb(1'b1, ADDR_CCR, 32'h1);
      step(2);
      chk("irq masked", irq_req_out, 0);
      wb(1'b1, ADDR_CCR, 32'h0);
      step(2);
      chk("irq again", irq_req_out, 1);
      ack_pulse();
      wb(1'b1, ADDR_OPTION, 32'h4);
      edges(20);
      chk("stopped", e, 0);
      src(2'h1, 1'b0);
      step(4);
      edges(40);
      chk("woken", e, 40 / BUS_DIV);
      ack_pulse();
      wb(1'b1, ADDR_OPTION, 32'h1);
      src(2'h1, 1'b0);
      rd("edge", ADDR_STATUS, exp_status(2'h0, 1'b0, 1'b1, 1'b1));
      ack_pulse();
      chk("edge acked", irq_req_out, 0);
      strap <= 2'h0;
      for (int k = 0; k < 2; k++)
      begin
         slow <= k ? 4'hC : 4'h0;
         watchdog_timer_fail_in <= !k;
         clock_monitor_fail_in  <= 1'(k);
         step(1);
         {watchdog_timer_fail_in, clock_monitor_fail_in} <= 2'h0;
         step(3);
         chk("pin driven", reset_pin_oe_out, 1);
         wait_run();
         rd("kind", ADDR_STATUS, exp_status(2'h0, internal(int'(slow)), 1'b0, 1'b0));
      end
      finish_test();
   end
endmodule : scpl_top_test
